// ---- hdl/pwtb_pkg.sv ----
package pwtb_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NGEN = 4;
	localparam int NPIN = 12;
	localparam int NSHARED = 8;
	localparam int ADDR_W = 8;
	localparam int TB_W = 16;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFF_PT_CTRL = 8'h00;
	localparam logic [7:0] OFF_SEV_CMP = 8'h04;
	localparam logic [7:0] OFF_PT_STAT = 8'h08;
	localparam logic [7:0] OFF_GEN_BASE = 8'h20;
	localparam logic [7:0] OFF_GEN_STRIDE = 8'h20;
	localparam logic [4:0] OFF_GEN_CTRL = 5'h00;
	localparam logic [4:0] OFF_GEN_TRIG = 5'h04;
	localparam logic [4:0] OFF_GEN_TCFG = 5'h08;
	localparam logic [4:0] OFF_GEN_BLANK = 5'h0C;
	localparam logic [4:0] OFF_GEN_FLC = 5'h10;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int PT_PS_LSB = 0;
	localparam int PT_SEIE_BIT = 4;
	localparam int GC_TRIE_BIT = 0;
	localparam int GC_FLTIE_BIT = 1;
	localparam int GC_LIMIE_BIT = 2;
	localparam int GC_LIMST_BIT = 8;
	localparam int GC_FLTST_BIT = 9;
	localparam int GC_TRST_BIT = 10;
	localparam int BL_LEN_LSB = 3;
	localparam int BL_LBEN_BIT = 10;
	localparam int BL_FBEN_BIT = 11;
	localparam int BL_LF_BIT = 12;
	localparam int BL_LR_BIT = 13;
	localparam int BL_HF_BIT = 14;
	localparam int BL_HR_BIT = 15;
	localparam int FC_LSRC_LSB = 0;
	localparam int FC_FSRC_LSB = 4;
	localparam int FC_FPOL_BIT = 8;
	localparam int FC_LPOL_BIT = 9;
	localparam int FC_FMOD_LSB = 10;

	// ----------------------------------------
	// Fault modes
	// ----------------------------------------
	localparam logic [1:0] FMOD_LATCHED = 2'h0;
	localparam logic [1:0] FMOD_CYCLE = 2'h1;
	localparam logic [1:0] FMOD_OFF = 2'h3;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int BLANK_STEP_PS = 8400;
	localparam int BLANK_STEP_CYC = (BLANK_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int BLANK_W = 10;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [TB_W-1:0] count;
		logic [TB_W-1:0] period;
		logic high;
		logic low;
		logic dead_nonzero;
	} pwtb_gen_pwm_t;

	typedef struct packed {
		logic trigger_irq_enable;
		logic fault_irq_enable;
		logic limit_irq_enable;
		logic [15:0] generator_trigger_compare;
		logic [2:0] trigger_divide_select;
		logic [6:0] blanking_length;
		logic high_rise_blank_sel;
		logic high_fall_blank_sel;
		logic low_rise_blank_sel;
		logic low_fall_blank_sel;
		logic fault_blank_enable;
		logic limit_blank_enable;
		logic [3:0] limit_source_select;
		logic [3:0] fault_source_select;
		logic fault_polarity;
		logic limit_polarity;
		logic [1:0] fault_mode_select;
	} pwtb_gen_cfg_t;

	localparam pwtb_gen_cfg_t GEN_CFG_RESET = '{
		fault_mode_select: FMOD_OFF,
		default: '0
	};

endpackage

// ---- hdl/pwtb_top.sv ----
`timescale 1ns/1ps

// Summary of operation
// - Special event postscale 1:1 to 1:16
// - Compare write or reset clears postscaler
// - Trigger when time base equals compare
// - Compare within period always triggers
// - Trigger interrupt when its enable set
// - Divider passes one per N triggers
// - Generator request ORs trigger, limit, fault
// - Four generator requests plus special request
// - Special interrupt only when enabled
// - Shared pins any generator, individual own
// - Limit input plus fault-or-limit input
// - Blanking ignores inputs after chosen edges
// - Four bits pick blanking start edges
// - New edge reloads running blanking timer
// - Separate blanking enables fault and limit
// - Blanking length is field plus one
// - Input held across boundary bypasses blanking at the cycle start only, when dead time is nonzero
// - Four-bit fault source among twelve pins
// - Fault requests only when enabled
// - Fault polarity bit inverts selected input
// - Fault override and request are combinational
// - Status shows latch or input level
// - Latched fault holds until clear, boundary, when its request is enabled
// - Cycle mode releases at next cycle
// - Two-bit field selects fault mode
module pwtb_top #(
	parameter int NGEN = pwtb_pkg::NGEN,
	parameter int NPIN = pwtb_pkg::NPIN
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [pwtb_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [pwtb_pkg::TB_W-1:0] primary_timebase_counter,
	input wire pwtb_pkg::pwtb_gen_pwm_t [NGEN-1:0] gen_pwm,
	input wire logic [NPIN-1:0] fault_input,
	output logic [NGEN-1:0] adc_trigger,
	output logic special_event_trigger,
	output logic [NGEN-1:0] gen_irq,
	output logic special_event_irq,
	output logic [NGEN-1:0] fault_override
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------

	// Pin mux; an individual pin is visible only to its own generator
	function automatic logic pin_pick(input logic [NPIN-1:0] pins, input logic [3:0] src, input int g);
		logic v;
		v = 1'b0;
		if (int'(src) < pwtb_pkg::NSHARED) begin
			v = pins[src];
		end else if (int'(src) == pwtb_pkg::NSHARED + g && int'(src) < NPIN) begin
			v = pins[src];
		end
		return v;
	endfunction

	// Blanking load value: (field + 1) steps of 3 clock cycles each, 8.4 ns rounded up to 12 ns
	function automatic logic [pwtb_pkg::BLANK_W-1:0] blank_cycles(input logic [6:0] len);
		logic [pwtb_pkg::BLANK_W-1:0] n;
		n = pwtb_pkg::BLANK_W'((32'(len) + 32'd1) * pwtb_pkg::BLANK_STEP_CYC);
		return n;
	endfunction

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	logic dp_write_r;
	logic [pwtb_pkg::ADDR_W-1:0] dp_addr_r;
	logic [3:0] postscale_r;
	logic sev_ie_r;
	logic [15:0] sev_cmp_r;
	logic sev_flag_r;
	pwtb_pkg::pwtb_gen_cfg_t cfg_r [NGEN];
	logic [NGEN-1:0] trig_flag_r;
	logic [NGEN-1:0] lim_flag_r;
	logic [NGEN-1:0] fault_latch_r;
	logic [NGEN-1:0] fault_lvl;
	logic [NGEN-1:0] lim_lvl;
	logic addr_phase;
	logic sev_cmp_wr;
	logic pt_stat_wr;
	logic [NGEN-1:0] gc_wr;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_phase = hsel && htrans[1] && hready;

	// Register the address phase; every access is a zero-wait single word
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			dp_write_r <= 1'b0;
			dp_addr_r <= '0;
		end else begin
			dp_write_r <= addr_phase && hwrite;
			dp_addr_r <= haddr;
		end
	end

	// Write strobes that have side effects beyond storing
	assign sev_cmp_wr = dp_write_r && dp_addr_r == pwtb_pkg::OFF_SEV_CMP;
	assign pt_stat_wr = dp_write_r && dp_addr_r == pwtb_pkg::OFF_PT_STAT;
	always_comb begin
		for (int g = 0; g < NGEN; g++) begin
			gc_wr[g] = dp_write_r &&
				dp_addr_r == pwtb_pkg::ADDR_W'(pwtb_pkg::OFF_GEN_BASE + g * pwtb_pkg::OFF_GEN_STRIDE);
		end
	end

	// Primary time base registers
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			postscale_r <= 4'h0;
			sev_ie_r <= 1'b0;
			sev_cmp_r <= 16'h0000;
		end else if (dp_write_r && dp_addr_r == pwtb_pkg::OFF_PT_CTRL) begin
			postscale_r <= hwdata[pwtb_pkg::PT_PS_LSB +: 4];
			sev_ie_r <= hwdata[pwtb_pkg::PT_SEIE_BIT];
		end else if (sev_cmp_wr) begin
			sev_cmp_r <= hwdata[15:0];
		end
	end

	// Generator configuration registers
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			for (int g = 0; g < NGEN; g++) begin
				cfg_r[g] <= pwtb_pkg::GEN_CFG_RESET;
			end
		end else if (dp_write_r) begin
			for (int g = 0; g < NGEN; g++) begin
				case (dp_addr_r - pwtb_pkg::ADDR_W'(pwtb_pkg::OFF_GEN_BASE + g * pwtb_pkg::OFF_GEN_STRIDE))
					8'(pwtb_pkg::OFF_GEN_CTRL): begin
						cfg_r[g].trigger_irq_enable <= hwdata[pwtb_pkg::GC_TRIE_BIT];
						cfg_r[g].fault_irq_enable <= hwdata[pwtb_pkg::GC_FLTIE_BIT];
						cfg_r[g].limit_irq_enable <= hwdata[pwtb_pkg::GC_LIMIE_BIT];
					end
					8'(pwtb_pkg::OFF_GEN_TRIG): begin
						cfg_r[g].generator_trigger_compare <= hwdata[15:0];
					end
					8'(pwtb_pkg::OFF_GEN_TCFG): begin
						cfg_r[g].trigger_divide_select <= hwdata[2:0];
					end
					8'(pwtb_pkg::OFF_GEN_BLANK): begin
						cfg_r[g].blanking_length <= hwdata[pwtb_pkg::BL_LEN_LSB +: 7];
						cfg_r[g].high_rise_blank_sel <= hwdata[pwtb_pkg::BL_HR_BIT];
						cfg_r[g].high_fall_blank_sel <= hwdata[pwtb_pkg::BL_HF_BIT];
						cfg_r[g].low_rise_blank_sel <= hwdata[pwtb_pkg::BL_LR_BIT];
						cfg_r[g].low_fall_blank_sel <= hwdata[pwtb_pkg::BL_LF_BIT];
						cfg_r[g].fault_blank_enable <= hwdata[pwtb_pkg::BL_FBEN_BIT];
						cfg_r[g].limit_blank_enable <= hwdata[pwtb_pkg::BL_LBEN_BIT];
					end
					8'(pwtb_pkg::OFF_GEN_FLC): begin
						cfg_r[g].limit_source_select <= hwdata[pwtb_pkg::FC_LSRC_LSB +: 4];
						cfg_r[g].fault_source_select <= hwdata[pwtb_pkg::FC_FSRC_LSB +: 4];
						cfg_r[g].fault_polarity <= hwdata[pwtb_pkg::FC_FPOL_BIT];
						cfg_r[g].limit_polarity <= hwdata[pwtb_pkg::FC_LPOL_BIT];
						cfg_r[g].fault_mode_select <= hwdata[pwtb_pkg::FC_FMOD_LSB +: 2];
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Read mux, sampled in the address phase so data stands in the data phase
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_phase && !hwrite) begin
			hrdata <= 32'h0000_0000; // Unmapped addresses read zero
			if (haddr == pwtb_pkg::OFF_PT_CTRL) begin
				hrdata[pwtb_pkg::PT_PS_LSB +: 4] <= postscale_r;
				hrdata[pwtb_pkg::PT_SEIE_BIT] <= sev_ie_r;
			end else if (haddr == pwtb_pkg::OFF_SEV_CMP) begin
				hrdata[15:0] <= sev_cmp_r;
			end else if (haddr == pwtb_pkg::OFF_PT_STAT) begin
				hrdata[0] <= sev_flag_r;
			end
			for (int g = 0; g < NGEN; g++) begin
				case (haddr - pwtb_pkg::ADDR_W'(pwtb_pkg::OFF_GEN_BASE + g * pwtb_pkg::OFF_GEN_STRIDE))
					8'(pwtb_pkg::OFF_GEN_CTRL): begin
						hrdata[pwtb_pkg::GC_TRIE_BIT] <= cfg_r[g].trigger_irq_enable;
						hrdata[pwtb_pkg::GC_FLTIE_BIT] <= cfg_r[g].fault_irq_enable;
						hrdata[pwtb_pkg::GC_LIMIE_BIT] <= cfg_r[g].limit_irq_enable;
						hrdata[pwtb_pkg::GC_LIMST_BIT] <= cfg_r[g].limit_irq_enable ? lim_flag_r[g] : lim_lvl[g];
						// Latch when requests are on, else live input in positive logic
						hrdata[pwtb_pkg::GC_FLTST_BIT] <= cfg_r[g].fault_irq_enable ?
							fault_latch_r[g] : fault_lvl[g];
						hrdata[pwtb_pkg::GC_TRST_BIT] <= trig_flag_r[g];
					end
					8'(pwtb_pkg::OFF_GEN_TRIG): hrdata[15:0] <= cfg_r[g].generator_trigger_compare;
					8'(pwtb_pkg::OFF_GEN_TCFG): hrdata[2:0] <= cfg_r[g].trigger_divide_select;
					8'(pwtb_pkg::OFF_GEN_BLANK): begin
						hrdata[pwtb_pkg::BL_LEN_LSB +: 7] <= cfg_r[g].blanking_length;
						hrdata[pwtb_pkg::BL_HR_BIT] <= cfg_r[g].high_rise_blank_sel;
						hrdata[pwtb_pkg::BL_HF_BIT] <= cfg_r[g].high_fall_blank_sel;
						hrdata[pwtb_pkg::BL_LR_BIT] <= cfg_r[g].low_rise_blank_sel;
						hrdata[pwtb_pkg::BL_LF_BIT] <= cfg_r[g].low_fall_blank_sel;
						hrdata[pwtb_pkg::BL_FBEN_BIT] <= cfg_r[g].fault_blank_enable;
						hrdata[pwtb_pkg::BL_LBEN_BIT] <= cfg_r[g].limit_blank_enable;
					end
					8'(pwtb_pkg::OFF_GEN_FLC): begin
						hrdata[pwtb_pkg::FC_LSRC_LSB +: 4] <= cfg_r[g].limit_source_select;
						hrdata[pwtb_pkg::FC_FSRC_LSB +: 4] <= cfg_r[g].fault_source_select;
						hrdata[pwtb_pkg::FC_FPOL_BIT] <= cfg_r[g].fault_polarity;
						hrdata[pwtb_pkg::FC_LPOL_BIT] <= cfg_r[g].limit_polarity;
						hrdata[pwtb_pkg::FC_FMOD_LSB +: 2] <= cfg_r[g].fault_mode_select;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Special event trigger
	// ----------------------------------------
	logic sev_match_r;
	logic [3:0] ps_cnt_r;
	logic sev_event;

	// Match edge, so a stalled time base yields one event only
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sev_match_r <= 1'b0;
		end else begin
			sev_match_r <= primary_timebase_counter == sev_cmp_r;
		end
	end
	assign sev_event = primary_timebase_counter == sev_cmp_r && !sev_match_r;

	// Postscaler passes one event in (field + 1)
	always_ff @(posedge sys_clk) begin
		if (srst || sev_cmp_wr) begin
			ps_cnt_r <= 4'h0;
			special_event_trigger <= 1'b0;
		end else begin
			special_event_trigger <= sev_event && ps_cnt_r == postscale_r;
			if (sev_event) begin
				ps_cnt_r <= ps_cnt_r == postscale_r ? 4'h0 : ps_cnt_r + 4'h1;
			end
		end
	end

	// Sticky special request; a new event beats a write-one clear
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sev_flag_r <= 1'b0;
		end else if (special_event_trigger && sev_ie_r) begin
			sev_flag_r <= 1'b1;
		end else if (pt_stat_wr && hwdata[0]) begin
			sev_flag_r <= 1'b0;
		end
	end
	assign special_event_irq = sev_flag_r;

	// ----------------------------------------
	// Per-generator logic
	// ----------------------------------------
	for (genvar g = 0; g < NGEN; g++) begin : gen_unit
		logic match_r;
		logic trig_event;
		logic [2:0] div_cnt_r;
		logic [2:0] div_n;
		logic high_r;
		logic low_r;
		logic blank_start;
		logic [pwtb_pkg::BLANK_W-1:0] blank_cnt_r;
		logic blank_on;
		logic cycle_start;
		logic cycle_end;
		logic fault_prev_r;
		logic lim_prev_r;
		logic fault_q;
		logic lim_q;
		logic hold_r;
		logic fault_off;

		// Compare match; compare beyond period never matches
		always_ff @(posedge sys_clk) begin
			if (srst) begin
				match_r <= 1'b0;
			end else begin
				match_r <= gen_pwm[g].count == cfg_r[g].generator_trigger_compare;
			end
		end
		assign trig_event = gen_pwm[g].count == cfg_r[g].generator_trigger_compare && !match_r &&
			cfg_r[g].generator_trigger_compare <= gen_pwm[g].period;

		// Field values 0 and 1 both pass every event
		assign div_n = cfg_r[g].trigger_divide_select == 3'h0 ? 3'h1 : cfg_r[g].trigger_divide_select;

		// Divider and the one-cycle ADC pulse
		always_ff @(posedge sys_clk) begin
			if (srst) begin
				div_cnt_r <= 3'h0;
				adc_trigger[g] <= 1'b0;
			end else begin
				adc_trigger[g] <= trig_event && div_cnt_r + 3'h1 >= div_n;
				if (trig_event) begin
					div_cnt_r <= div_cnt_r + 3'h1 >= div_n ? 3'h0 : div_cnt_r + 3'h1;
				end
			end
		end

		// Trigger request flag, set wins over a write-one clear
		always_ff @(posedge sys_clk) begin
			if (srst) begin
				trig_flag_r[g] <= 1'b0;
			end else if (trig_event && cfg_r[g].trigger_irq_enable) begin
				trig_flag_r[g] <= 1'b1;
			end else if (gc_wr[g] && hwdata[pwtb_pkg::GC_TRST_BIT]) begin
				trig_flag_r[g] <= 1'b0;
			end
		end

		// Coarse output edges that start or reload the blanking timer
		always_ff @(posedge sys_clk) begin
			if (srst) begin
				high_r <= 1'b0;
				low_r <= 1'b0;
			end else begin
				high_r <= gen_pwm[g].high;
				low_r <= gen_pwm[g].low;
			end
		end
		assign blank_start = (cfg_r[g].high_rise_blank_sel && gen_pwm[g].high && !high_r) ||
			(cfg_r[g].high_fall_blank_sel && !gen_pwm[g].high && high_r) ||
			(cfg_r[g].low_rise_blank_sel && gen_pwm[g].low && !low_r) ||
			(cfg_r[g].low_fall_blank_sel && !gen_pwm[g].low && low_r);

		always_ff @(posedge sys_clk) begin
			if (srst) begin
				blank_cnt_r <= '0;
			end else if (blank_start) begin
				blank_cnt_r <= blank_cycles(cfg_r[g].blanking_length);
			end else if (blank_cnt_r != '0) begin
				blank_cnt_r <= blank_cnt_r - pwtb_pkg::BLANK_W'(1);
			end
		end
		assign blank_on = blank_cnt_r != '0 || blank_start;

		// Selected inputs in positive logic
		assign fault_lvl[g] = pin_pick(fault_input, cfg_r[g].fault_source_select, g) ^
			cfg_r[g].fault_polarity;
		assign lim_lvl[g] = pin_pick(fault_input, cfg_r[g].limit_source_select, g) ^
			cfg_r[g].limit_polarity;

		assign cycle_start = gen_pwm[g].count == '0;
		assign cycle_end = gen_pwm[g].count == gen_pwm[g].period;

		// Remember inputs active at cycle end to bypass blanking at the next start
		always_ff @(posedge sys_clk) begin
			if (srst) begin
				fault_prev_r <= 1'b0;
				lim_prev_r <= 1'b0;
			end else if (cycle_end) begin
				fault_prev_r <= fault_lvl[g];
				lim_prev_r <= lim_lvl[g];
			end else if (!cycle_start) begin
				fault_prev_r <= 1'b0;
				lim_prev_r <= 1'b0;
			end
		end

		// Blanked inputs; a condition spanning the boundary is not hidden in the cycle-start cycle when dead time is nonzero
		assign fault_q = fault_lvl[g] && (!(blank_on && cfg_r[g].fault_blank_enable) ||
			(fault_prev_r && cycle_start && gen_pwm[g].dead_nonzero));
		assign lim_q = lim_lvl[g] && (!(blank_on && cfg_r[g].limit_blank_enable) ||
			(lim_prev_r && cycle_start && gen_pwm[g].dead_nonzero));

		// Fault request latch; clearing the enable bit clears it, a new fault wins
		always_ff @(posedge sys_clk) begin
			if (srst) begin
				fault_latch_r[g] <= 1'b0;
			end else if (fault_q && cfg_r[g].fault_irq_enable) begin
				fault_latch_r[g] <= 1'b1;
			end else if (gc_wr[g] && !hwdata[pwtb_pkg::GC_FLTIE_BIT]) begin
				fault_latch_r[g] <= 1'b0;
			end
		end

		// Limit request flag, write-one clear
		always_ff @(posedge sys_clk) begin
			if (srst) begin
				lim_flag_r[g] <= 1'b0;
			end else if (lim_q && cfg_r[g].limit_irq_enable) begin
				lim_flag_r[g] <= 1'b1;
			end else if (gc_wr[g] && hwdata[pwtb_pkg::GC_LIMST_BIT]) begin
				lim_flag_r[g] <= 1'b0;
			end
		end

		// Override hold; release at a cycle start once conditions allow, or at any edge when the mode is off
		assign fault_off = cfg_r[g].fault_mode_select == pwtb_pkg::FMOD_OFF;
		always_ff @(posedge sys_clk) begin
			if (srst || fault_off) begin
				hold_r <= 1'b0;
			end else if (fault_q) begin
				hold_r <= 1'b1;
			end else if (cycle_start) begin
				case (cfg_r[g].fault_mode_select)
					pwtb_pkg::FMOD_LATCHED: hold_r <= fault_latch_r[g];
					pwtb_pkg::FMOD_CYCLE: hold_r <= 1'b0;
					default: hold_r <= 1'b0;
				endcase
			end
		end

		// Override and request follow the pin without a clock edge
		assign fault_override[g] = !fault_off && (fault_q || hold_r);
		assign gen_irq[g] = trig_flag_r[g] || lim_flag_r[g] || fault_latch_r[g] ||
			(fault_q && cfg_r[g].fault_irq_enable);
	end

endmodule

// ---- tb/pwtb_assertions.sv ----
`timescale 1ns/1ps

// Pin-level checker for the trigger, interrupt and fault outputs
module pwtb_checker #(
	parameter int NGEN = 4,
	parameter int NPIN = 12
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [pwtb_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire pwtb_pkg::pwtb_gen_pwm_t [NGEN-1:0] gen_pwm,
	input wire logic [NPIN-1:0] fault_input,
	input wire logic [NGEN-1:0] adc_trigger,
	input wire logic special_event_trigger,
	input wire logic [NGEN-1:0] gen_irq,
	input wire logic special_event_irq,
	input wire logic [NGEN-1:0] fault_override
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	// A pulse that drops after exactly one cycle
	sequence s_one_cycle(x);
		x ##1 !x;
	endsequence

	// ----
	// Per generator
	// ----
	for (genvar g = 0; g < NGEN; g++) begin : gk
		a_trig_single: assert property (adc_trigger[g] |-> s_one_cycle(adc_trigger[g]))
			else $error("trigger pulse longer than one cycle");
		a_trig_period: assert property (adc_trigger[g] |-> $past(gen_pwm[g].count <= gen_pwm[g].period))
			else $error("trigger outside the period");
		a_trig_first: assert property (adc_trigger[g] |-> $past(gen_pwm[g].count) !=
			$past(gen_pwm[g].count, 2))
			else $error("trigger without a fresh match");
		a_release_edge: assert property ($fell(fault_override[g]) |->
			(gen_pwm[g].count == '0) || $past(gen_pwm[g].count == '0))
			else $error("fault released off the cycle boundary");
		// Every match with its request enabled sets the request, divided or not, so only a fresh count shows it
		a_irq_cause: assert property ($rose(gen_irq[g]) |-> fault_override[g] || (fault_input != '0)
			|| $past(gen_pwm[g].count) != $past(gen_pwm[g].count, 2))
			else $error("generator request without a source");
	end

	// ----
	// Special event and reset
	// ----
	a_sev_single: assert property (special_event_trigger |-> s_one_cycle(special_event_trigger))
		else $error("special pulse longer than one cycle");
	a_sev_irq_cause: assert property ($rose(special_event_irq) |->
		special_event_trigger || $past(special_event_trigger))
		else $error("special request without an event");
	a_sev_flag_clear: assert property ($fell(special_event_irq) |->
		$past(hsel && htrans[1] && hwrite && haddr == pwtb_pkg::OFF_PT_STAT, 2))
		else $error("special request dropped without a clear");
	// Reset must silence every request line one cycle on
	a_reset_quiet: assert property (disable iff (1'b0) srst |=> adc_trigger == '0 && gen_irq == '0
		&& fault_override == '0 && !special_event_trigger && !special_event_irq)
		else $error("outputs active after reset");
endmodule

bind pwtb_top pwtb_checker #(.NGEN(NGEN), .NPIN(NPIN)) u_checker (
	.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.gen_pwm(gen_pwm), .fault_input(fault_input), .adc_trigger(adc_trigger),
	.special_event_trigger(special_event_trigger), .gen_irq(gen_irq),
	.special_event_irq(special_event_irq), .fault_override(fault_override)
);

// ---- tb/pwtb_far_end.sv ----
`timescale 1ns/1ps

// Converter trigger inputs: log the spacing and number of pulses on each line
module pwtb_far_end (
	input wire logic sys_clk,
	input wire logic clr,
	input wire logic [4:0] pulse,
	output logic [15:0] gap [5],
	output logic [7:0] cnt [5]
);
	logic [15:0] now_r = 16'h0000;
	logic [15:0] last_r [5];

	// Gap is only trusted from the second pulse after a clear
	always_ff @(posedge sys_clk) begin
		now_r <= now_r + 16'h0001;
		for (int i = 0; i < 5; i++) begin
			if (clr) begin
				cnt[i] <= 8'h00;
				gap[i] <= 16'h0000;
			end else if (pulse[i]) begin
				cnt[i] <= cnt[i] + 8'h01;
				gap[i] <= now_r - last_r[i];
				last_r[i] <= now_r;
			end
		end
	end
endmodule

// ---- tb/pwtb_top_bench.sv ----
`timescale 1ns/1ps

module pwtb_top_bench;
	typedef struct {int g; logic [15:0] cmp; int dv; logic ie;} pwtb_row_t;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp, special_event_trigger, special_event_irq;
	logic clr = 1'b0;
	logic [15:0] cnt_r = 16'h0;
	logic [11:0] fault_input = 12'h0;
	logic [3:0] adc_trigger, gen_irq, fault_override;
	pwtb_pkg::pwtb_gen_pwm_t [3:0] gen_pwm;
	logic [15:0] gap [5];
	logic [7:0] hits [5];
	int failures = 0, tests_run = 0, n, g;
	int ps [3] = '{0, 3, 15};
	// Divider settings 0..7 spread over the generators; compare 0x10 is past the period
	pwtb_row_t rows [8] = '{'{0, 16'h5, 0, 1'b1}, '{1, 16'h0, 2, 1'b0}, '{2, 16'hF, 3, 1'b1},
		'{3, 16'h7, 6, 1'b0}, '{0, 16'h10, 1, 1'b1}, '{1, 16'h3, 4, 1'b1}, '{2, 16'h9, 5, 1'b0},
		'{3, 16'h1, 7, 1'b1}};

	always #2 sys_clk = ~sys_clk;

	// Shared time base of period 16 with a nonzero dead time
	always @(posedge sys_clk) begin
		cnt_r <= (cnt_r == 16'h000F) ? 16'h0000 : cnt_r + 16'h0001;
	end
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			gen_pwm[i] = {cnt_r, 16'h000F, cnt_r < 16'h0008, cnt_r >= 16'h0008, 1'b1};
		end
	end

	pwtb_top DUT (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .primary_timebase_counter(cnt_r), .gen_pwm(gen_pwm),
		.fault_input(fault_input), .adc_trigger(adc_trigger), .special_event_trigger(special_event_trigger),
		.gen_irq(gen_irq), .special_event_irq(special_event_irq), .fault_override(fault_override));
	pwtb_far_end FAR (.sys_clk(sys_clk), .clr(clr), .pulse({special_event_trigger, adc_trigger}),
		.gap(gap), .cnt(hits));

	// ----
	// Helpers
	// ----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Single AHB word transfer; waits on hready in both phases
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do begin @(posedge sys_clk); k++; end while (hreadyout !== 1'b1 && k < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin @(posedge sys_clk); k++; end while (hreadyout !== 1'b1 && k < 100);
		r = hrdata;
	endtask

	function automatic logic [7:0] ga(int k, logic [4:0] o);
		return pwtb_pkg::OFF_GEN_BASE + 8'(k) * pwtb_pkg::OFF_GEN_STRIDE + {3'h0, o};
	endfunction

	// Returns at the edge that moves the time base off value v
	task automatic wait_cnt(input logic [15:0] v);
		int k;
		k = 0;
		do begin @(posedge sys_clk); k++; end while (cnt_r !== v && k < 40);
	endtask

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Cuts a hang well past the expected few thousand cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		wrap_up();
	end

	// ----
	// Main sequence
	// ----
	initial begin
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		bus(1'b0, ga(0, pwtb_pkg::OFF_GEN_FLC), 32'h0, rd);
		check(rd, 32'h00000C00);
		// Trigger rows: quiet the flag, program, then time the pulses
		foreach (rows[i]) begin
			g = rows[i].g;
			n = (rows[i].dv < 2) ? 1 : rows[i].dv;
			bus(1'b1, ga(g, pwtb_pkg::OFF_GEN_CTRL), 32'h400, rd);
			bus(1'b1, ga(g, pwtb_pkg::OFF_GEN_TRIG), {16'h0, rows[i].cmp}, rd);
			bus(1'b1, ga(g, pwtb_pkg::OFF_GEN_TCFG), 32'(rows[i].dv), rd);
			bus(1'b1, ga(g, pwtb_pkg::OFF_GEN_CTRL), {21'h0, 1'b1, 9'h0, rows[i].ie}, rd);
			clr <= 1'b1;
			@(posedge sys_clk);
			clr <= 1'b0;
			repeat ((2 * n + 2) * 16) @(posedge sys_clk);
			#1;
			check({16'h0, gap[g]}, (rows[i].cmp > 16'hF) ? 32'h0 : 32'(n * 16));
			check(gen_irq[g], rows[i].ie && rows[i].cmp <= 16'hF);
			check(32'(hits[g] > 8'h1), 32'(rows[i].cmp <= 16'hF));
		end
		// Special event postscale ratios, request enabled only for nonzero settings
		foreach (ps[i]) begin
			bus(1'b1, pwtb_pkg::OFF_PT_CTRL, {27'h0, ps[i] != 0, 4'(ps[i])}, rd);
			bus(1'b1, pwtb_pkg::OFF_SEV_CMP, 32'h2, rd);
			bus(1'b1, pwtb_pkg::OFF_PT_STAT, 32'h1, rd);
			clr <= 1'b1;
			@(posedge sys_clk);
			clr <= 1'b0;
			repeat ((2 * ps[i] + 4) * 16) @(posedge sys_clk);
			#1;
			check({16'h0, gap[4]}, 32'((ps[i] + 1) * 16));
			check(special_event_irq, ps[i] != 0);
		end
		// A compare write restarts the 1:16 count
		bus(1'b1, pwtb_pkg::OFF_SEV_CMP, 32'h2, rd);
		n = 0;
		while (special_event_trigger !== 1'b1 && n < 400) begin @(posedge sys_clk); #1; n++; end
		check(32'(n > 239 && n < 290), 32'h1);
		// Cycle-by-cycle fault on generator 1 from its own pin; generator 0 may not use it
		bus(1'b1, ga(0, pwtb_pkg::OFF_GEN_FLC), 32'h490, rd);
		bus(1'b1, ga(1, pwtb_pkg::OFF_GEN_FLC), 32'h490, rd);
		bus(1'b1, ga(1, pwtb_pkg::OFF_GEN_CTRL), 32'h402, rd);
		wait_cnt(16'h3);
		fault_input[9] <= 1'b1;
		#1;
		check(fault_override[1], 1'b1);
		check(gen_irq[1], 1'b1);
		check(fault_override[0], 1'b0);
		@(posedge sys_clk);
		fault_input[9] <= 1'b0;
		#1;
		check(fault_override[1], 1'b1);
		wait_cnt(16'h1);
		#1;
		check(fault_override[1], 1'b0);
		bus(1'b0, ga(1, pwtb_pkg::OFF_GEN_CTRL), 32'h0, rd);
		check(rd & 32'h200, 32'h200);
		bus(1'b1, ga(1, pwtb_pkg::OFF_GEN_CTRL), 32'h0, rd);
		fault_input[9] <= 1'b1;
		bus(1'b0, ga(1, pwtb_pkg::OFF_GEN_CTRL), 32'h0, rd);
		check(rd & 32'h200, 32'h200);
		fault_input[9] <= 1'b0;
		bus(1'b1, ga(1, pwtb_pkg::OFF_GEN_FLC), 32'h590, rd);
		@(posedge sys_clk);
		#1;
		check(fault_override[1], 1'b1);
		// Shortest blanking after a high-side rise: three cycles hide the pin
		bus(1'b1, ga(2, pwtb_pkg::OFF_GEN_FLC), 32'h4A0, rd);
		bus(1'b1, ga(2, pwtb_pkg::OFF_GEN_BLANK), 32'h8800, rd);
		wait_cnt(16'h0);
		fault_input[10] <= 1'b1;
		#1;
		check(fault_override[2], 1'b0);
		repeat (3) @(posedge sys_clk);
		#1;
		check(fault_override[2], 1'b1);
		// Reset in mid-run drops everything back to defaults
		@(posedge sys_clk);
		fault_input[10] <= 1'b0;
		srst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		#1;
		check(fault_override, 4'h0);
		bus(1'b0, 8'hFC, 32'h0, rd);
		check(rd, 32'h0);
		check(hresp, 1'b0);
		bus(1'b0, ga(1, pwtb_pkg::OFF_GEN_FLC), 32'h0, rd);
		check(rd, 32'h00000C00);
		wrap_up();
	end
endmodule
